//--- inc/phi_pkg.sv
package phi_pkg;

  // host cycle variants served by both ends
  typedef enum logic [1:0] {
    PHI_DIR80_T2,
    PHI_DIR80_T3,
    PHI_DIR68,
    PHI_IND80_T1
  } phi_mode_t;

  localparam int PHI_DW = 16;
  localparam int PHI_AW = 18;

  // timing, system clock at 50 MHz
  localparam int PHI_TS_NS = 20;
  localparam int PHI_RD_MARGIN_NS = 25;
  localparam int PHI_RD_MARGIN_CYC = (PHI_RD_MARGIN_NS + PHI_TS_NS - 1) / PHI_TS_NS;
  localparam int PHI_WR_EXTRA_CYC = 3;
  localparam int PHI_WAIT_LEN_DEF = 4;
  localparam int PHI_WAIT_SEEN_CYC = 2;

  // indirect index layout: top bit picks memory, the rest is the word address
  localparam int PHI_IDX_MEM_BIT = 15;
  localparam int PHI_IDX_ADDR_W = 15;

  localparam logic [1:0] PHI_LANES_ALL = 2'h3;
  localparam logic [1:0] PHI_LANES_NONE = 2'h0;
  localparam logic [15:0] PHI_DATA_IDLE = 16'hffff;
  localparam logic [15:0] PHI_INDEX_RST = 16'h0000;

endpackage : phi_pkg

//--- inc/phi_bus_if.sv
`timescale 1ns/10ps
`default_nettype none

interface phi_bus_if;
  // host driven
  logic cs_n;
  logic [17:0] addr;
  logic mem_not_reg;
  logic index_or_data_select;
  logic write_n;
  logic read_n;
  logic write_strobe_upper_n;
  logic write_strobe_lower_n;
  logic read_strobe_upper_n;
  logic read_strobe_lower_n;
  logic upper_byte_enable_n;
  logic lower_byte_enable_n;
  logic upper_data_strobe_n;
  logic lower_data_strobe_n;
  logic read_not_write;
  logic [15:0] h_data_o;
  logic h_data_oe;
  // device driven
  logic [15:0] d_data_o;
  logic d_data_oe;
  logic d_wait_n_o;
  logic d_wait_oe;
  // resolved wires, pull-ups where nobody drives
  logic [15:0] data;
  logic wait_n;

  assign data = d_data_oe ? d_data_o : (h_data_oe ? h_data_o : 16'hffff);
  assign wait_n = d_wait_oe ? d_wait_n_o : 1'b1;

  modport host (
    output cs_n, addr, mem_not_reg, index_or_data_select, write_n, read_n,
    output write_strobe_upper_n, write_strobe_lower_n, read_strobe_upper_n, read_strobe_lower_n,
    output upper_byte_enable_n, lower_byte_enable_n, upper_data_strobe_n, lower_data_strobe_n,
    output read_not_write, h_data_o, h_data_oe,
    input data, wait_n
  );

  modport dev (
    input cs_n, addr, mem_not_reg, index_or_data_select, write_n, read_n,
    input write_strobe_upper_n, write_strobe_lower_n, read_strobe_upper_n, read_strobe_lower_n,
    input upper_byte_enable_n, lower_byte_enable_n, upper_data_strobe_n, lower_data_strobe_n,
    input read_not_write, data,
    output d_data_o, d_data_oe, d_wait_n_o, d_wait_oe
  );
endinterface : phi_bus_if

`default_nettype wire

//--- design/phi_dev_end.sv
// How it works
// - no byte address bit; lanes pick bytes
// - no-wait host stretches by wait length
// - no-wait write lasts wait length plus three
// - no-wait read sampled after length plus 25ns
// - wait driven low on read or write, floats after
// - data valid once wait released high
// - data driven from a clock after read strobe falls to a clock after it rises
// - direct host presents word address and select
// - split write strobes, single 16-bit read
// - split read strobes pick byte lanes
// - endian setting maps lanes to bytes
// - 68 direction line low writes, high reads
// - 68 direction stable around data strobes
// - indirect select and enables stable around strobes
// - indirect select low loads index register
// - indirect register data always 16 bits
// - indirect bytes only for memory data
`timescale 1ns/10ps
`default_nettype none

module phi_dev_end
  import phi_pkg::*;
(
  // clock and reset
  input wire logic CLK_I,
  input wire logic RST_N_I,
  // configuration
  input wire phi_mode_t MODE_I,
  input wire logic WAIT_EN_I,
  input wire logic BIG_ENDIAN_I,
  // host pins
  phi_bus_if.dev BUS,
  // internal access port
  output logic REQ_O,
  output logic WR_O,
  output logic MEM_O,
  output logic [PHI_AW-1:0] ADDR_O,
  output logic [1:0] BE_O,
  output logic [PHI_DW-1:0] WDATA_O,
  input wire logic ACK_I,
  input wire logic [PHI_DW-1:0] RDATA_I,
  // index register seen by the register space
  output logic [PHI_DW-1:0] INDEX_O
);

  typedef enum logic [1:0] {
    DS_IDLE,
    DS_BUSY,
    DS_DONE
  } phi_dst_t;

  typedef struct packed {
    phi_dst_t st;
    logic [PHI_DW-1:0] index;
    logic wait_n;
    logic wait_oe;
    logic [PHI_DW-1:0] dout;
    logic doe;
    logic req;
    logic uwr;
    logic umem;
    logic [PHI_AW-1:0] uaddr;
    logic [1:0] ube;
    logic [PHI_DW-1:0] uwdata;
  } phi_dstate_t;

  phi_dstate_t s_q;
  phi_dstate_t s_d;

  logic rd_hi;
  logic rd_lo;
  logic wr_hi;
  logic wr_lo;
  logic rd_act;
  logic wr_act;
  logic indirect;

  // lanes as byte enables, bit 0 is the even byte
  function automatic logic [1:0] lane_to_be(input logic big, input logic [1:0] lanes);
    lane_to_be = big ? {lanes[0], lanes[1]} : lanes;
  endfunction : lane_to_be

  function automatic logic [PHI_DW-1:0] swap(input logic big, input logic [PHI_DW-1:0] d);
    swap = big ? {d[7:0], d[15:8]} : d;
  endfunction : swap

  // strobe decode per variant; inputs taken as synchronous
  always_comb begin
    rd_hi = 1'b0;
    rd_lo = 1'b0;
    wr_hi = 1'b0;
    wr_lo = 1'b0;
    case (MODE_I)
      PHI_DIR80_T2: begin
        wr_hi = !BUS.write_strobe_upper_n;
        wr_lo = !BUS.write_strobe_lower_n;
        rd_hi = !BUS.read_n;
        rd_lo = !BUS.read_n;
      end
      PHI_DIR80_T3: begin
        wr_hi = !BUS.write_strobe_upper_n;
        wr_lo = !BUS.write_strobe_lower_n;
        rd_hi = !BUS.read_strobe_upper_n;
        rd_lo = !BUS.read_strobe_lower_n;
      end
      PHI_DIR68: begin
        rd_hi = BUS.read_not_write && !BUS.upper_data_strobe_n;
        rd_lo = BUS.read_not_write && !BUS.lower_data_strobe_n;
        wr_hi = !BUS.read_not_write && !BUS.upper_data_strobe_n;
        wr_lo = !BUS.read_not_write && !BUS.lower_data_strobe_n;
      end
      PHI_IND80_T1: begin
        rd_hi = !BUS.read_n && !BUS.upper_byte_enable_n;
        rd_lo = !BUS.read_n && !BUS.lower_byte_enable_n;
        wr_hi = !BUS.write_n && !BUS.upper_byte_enable_n;
        wr_lo = !BUS.write_n && !BUS.lower_byte_enable_n;
      end
      default: begin
        rd_hi = 1'b0;
      end
    endcase
  end

  assign rd_act = !BUS.cs_n && (rd_hi || rd_lo);
  assign wr_act = !BUS.cs_n && (wr_hi || wr_lo);
  assign indirect = (MODE_I == PHI_IND80_T1);

  always_comb begin
    s_d = s_q;
    // bus driven from one clock after a read strobe falls, released one clock after it rises
    s_d.doe = rd_act;
    case (s_q.st)
      DS_IDLE: begin
        if (rd_act || wr_act) begin
          s_d.wait_oe = WAIT_EN_I;
          s_d.wait_n = 1'b0;
          if (indirect && !BUS.index_or_data_select && wr_act) begin
            // command write: the whole word becomes the index
            s_d.index = BUS.data;
            s_d.st = DS_DONE;
          end else begin
            s_d.req = 1'b1;
            s_d.uwr = wr_act;
            s_d.uwdata = swap(BIG_ENDIAN_I, BUS.data);
            s_d.ube = lane_to_be(BIG_ENDIAN_I, wr_act ? {wr_hi, wr_lo} : {rd_hi, rd_lo});
            if (indirect) begin
              s_d.umem = s_q.index[PHI_IDX_MEM_BIT];
              s_d.uaddr = {3'h0, s_q.index[PHI_IDX_ADDR_W-1:0]};
              // register space ignores the enables: always a full word
              if (!s_q.index[PHI_IDX_MEM_BIT]) begin
                s_d.ube = PHI_LANES_ALL;
              end
            end else begin
              s_d.umem = BUS.mem_not_reg;
              s_d.uaddr = BUS.addr;
            end
            s_d.st = DS_BUSY;
          end
        end
      end
      DS_BUSY: begin
        // wait stays low until the internal side answers
        if (ACK_I) begin
          s_d.req = 1'b0;
          if (!s_q.uwr) begin
            s_d.dout = swap(BIG_ENDIAN_I, RDATA_I);
          end
          s_d.wait_n = 1'b1;
          s_d.st = DS_DONE;
        end
      end
      DS_DONE: begin
        s_d.wait_n = 1'b1;
        if (!(rd_act || wr_act)) begin
          s_d.wait_oe = 1'b0;
          s_d.st = DS_IDLE;
        end
      end
      default: begin
        s_d.st = DS_IDLE;
      end
    endcase
  end

  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      s_q.st <= DS_IDLE;
      s_q.index <= PHI_INDEX_RST;
      s_q.wait_n <= 1'b1;
      s_q.wait_oe <= 1'b0;
      s_q.dout <= PHI_DATA_IDLE;
      s_q.doe <= 1'b0;
      s_q.req <= 1'b0;
      s_q.uwr <= 1'b0;
      s_q.umem <= 1'b0;
      s_q.uaddr <= 18'h00000;
      s_q.ube <= PHI_LANES_NONE;
      s_q.uwdata <= 16'h0000;
    end else begin
      s_q <= s_d;
    end
  end

  assign BUS.d_data_o = s_q.dout;
  assign BUS.d_data_oe = s_q.doe;
  assign BUS.d_wait_n_o = s_q.wait_n;
  assign BUS.d_wait_oe = s_q.wait_oe;
  assign REQ_O = s_q.req;
  assign WR_O = s_q.uwr;
  assign MEM_O = s_q.umem;
  assign ADDR_O = s_q.uaddr;
  assign BE_O = s_q.ube;
  assign WDATA_O = s_q.uwdata;
  assign INDEX_O = s_q.index;

endmodule : phi_dev_end

`default_nettype wire

//--- design/phi_host_end.sv
`timescale 1ns/10ps
`default_nettype none

module phi_host_end
  import phi_pkg::*;
#(
  parameter int WAIT_LEN = PHI_WAIT_LEN_DEF
)
(
  // clock and reset
  input wire logic CLK_I,
  input wire logic RST_N_I,
  // configuration
  input wire phi_mode_t MODE_I,
  input wire logic WAIT_EN_I,
  // user request
  input wire logic REQ_I,
  input wire logic WR_I,
  input wire logic MEM_I,
  input wire logic SEL_I,
  input wire logic [PHI_AW-1:0] ADDR_I,
  input wire logic [1:0] LANES_I,
  input wire logic [PHI_DW-1:0] WDATA_I,
  // user answer
  output logic BUSY_O,
  output logic DONE_O,
  output logic [PHI_DW-1:0] RDATA_O,
  // device pins
  phi_bus_if.host BUS
);

  localparam logic [7:0] WR_HOLD = 8'(WAIT_LEN + PHI_WR_EXTRA_CYC);
  localparam logic [7:0] RD_HOLD = 8'(WAIT_LEN + PHI_RD_MARGIN_CYC);
  localparam logic [7:0] SEEN = 8'(PHI_WAIT_SEEN_CYC);

  typedef enum logic [1:0] {
    HS_IDLE,
    HS_SETUP,
    HS_STROBE,
    HS_RECOVER
  } phi_hst_t;

  typedef struct packed {
    phi_hst_t st;
    logic [7:0] cnt;
    logic wr;
    logic [1:0] lanes;
    logic cs_n;
    logic [PHI_AW-1:0] addr;
    logic mem;
    logic sel;
    logic wn;
    logic rn;
    logic wsu_n;
    logic wsl_n;
    logic rsu_n;
    logic rsl_n;
    logic ube_n;
    logic lbe_n;
    logic uds_n;
    logic lds_n;
    logic rnw;
    logic [PHI_DW-1:0] dout;
    logic doe;
    logic busy;
    logic done;
    logic [PHI_DW-1:0] rdata;
  } phi_hstate_t;

  phi_hstate_t h_q;
  phi_hstate_t h_d;
  logic finish;

  always_comb begin
    h_d = h_q;
    h_d.done = 1'b0;
    finish = 1'b0;
    case (h_q.st)
      HS_IDLE: begin
        if (REQ_I) begin
          // select, address and enables set one clock ahead of the strobe
          h_d.wr = WR_I;
          h_d.lanes = LANES_I;
          h_d.cs_n = 1'b0;
          h_d.addr = ADDR_I;
          h_d.mem = MEM_I;
          h_d.sel = SEL_I;
          h_d.ube_n = !LANES_I[1];
          h_d.lbe_n = !LANES_I[0];
          h_d.rnw = !WR_I;
          h_d.dout = WDATA_I;
          h_d.doe = WR_I;
          h_d.busy = 1'b1;
          h_d.st = HS_SETUP;
        end
      end
      HS_SETUP: begin
        h_d.cnt = 8'h00;
        case (MODE_I)
          PHI_DIR80_T2: begin
            h_d.wsu_n = !(h_q.wr && h_q.lanes[1]);
            h_d.wsl_n = !(h_q.wr && h_q.lanes[0]);
            h_d.rn = h_q.wr;
          end
          PHI_DIR80_T3: begin
            h_d.wsu_n = !(h_q.wr && h_q.lanes[1]);
            h_d.wsl_n = !(h_q.wr && h_q.lanes[0]);
            h_d.rsu_n = !(!h_q.wr && h_q.lanes[1]);
            h_d.rsl_n = !(!h_q.wr && h_q.lanes[0]);
          end
          PHI_DIR68: begin
            h_d.uds_n = !h_q.lanes[1];
            h_d.lds_n = !h_q.lanes[0];
          end
          PHI_IND80_T1: begin
            h_d.wn = !h_q.wr;
            h_d.rn = h_q.wr;
          end
          default: begin
            h_d.st = HS_IDLE;
          end
        endcase
        h_d.st = HS_STROBE;
      end
      HS_STROBE: begin
        h_d.cnt = h_q.cnt + 8'h01;
        if (WAIT_EN_I) begin
          // read data taken only once the device has let wait rise
          finish = (h_q.cnt >= SEEN) && BUS.wait_n;
        end else begin
          finish = h_q.cnt >= (h_q.wr ? WR_HOLD : RD_HOLD);
        end
        if (finish) begin
          if (!h_q.wr) begin
            h_d.rdata = BUS.data;
          end
          h_d.wn = 1'b1;
          h_d.rn = 1'b1;
          h_d.wsu_n = 1'b1;
          h_d.wsl_n = 1'b1;
          h_d.rsu_n = 1'b1;
          h_d.rsl_n = 1'b1;
          h_d.uds_n = 1'b1;
          h_d.lds_n = 1'b1;
          h_d.st = HS_RECOVER;
        end
      end
      HS_RECOVER: begin
        // address and direction held one clock past the strobe
        h_d.cs_n = 1'b1;
        h_d.doe = 1'b0;
        h_d.busy = 1'b0;
        h_d.done = 1'b1;
        h_d.st = HS_IDLE;
      end
      default: begin
        h_d.st = HS_IDLE;
      end
    endcase
  end

  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      h_q <= '{st: HS_IDLE, cnt: 8'h00, wr: 1'b0, lanes: 2'h0, addr: 18'h00000, mem: 1'b0,
               sel: 1'b0, rnw: 1'b1, dout: 16'h0000, doe: 1'b0, busy: 1'b0, done: 1'b0,
               rdata: 16'h0000, default: 1'b1};
    end else begin
      h_q <= h_d;
    end
  end

  assign BUS.cs_n = h_q.cs_n;
  assign BUS.addr = h_q.addr;
  assign BUS.mem_not_reg = h_q.mem;
  assign BUS.index_or_data_select = h_q.sel;
  assign BUS.write_n = h_q.wn;
  assign BUS.read_n = h_q.rn;
  assign BUS.write_strobe_upper_n = h_q.wsu_n;
  assign BUS.write_strobe_lower_n = h_q.wsl_n;
  assign BUS.read_strobe_upper_n = h_q.rsu_n;
  assign BUS.read_strobe_lower_n = h_q.rsl_n;
  assign BUS.upper_byte_enable_n = h_q.ube_n;
  assign BUS.lower_byte_enable_n = h_q.lbe_n;
  assign BUS.upper_data_strobe_n = h_q.uds_n;
  assign BUS.lower_data_strobe_n = h_q.lds_n;
  assign BUS.read_not_write = h_q.rnw;
  assign BUS.h_data_o = h_q.dout;
  assign BUS.h_data_oe = h_q.doe;
  assign BUSY_O = h_q.busy;
  assign DONE_O = h_q.done;
  assign RDATA_O = h_q.rdata;

endmodule : phi_host_end

`default_nettype wire

//--- testbench/phi_bus_assertions.sv
`timescale 1ns/10ps
`default_nettype none

module phi_bus_assertions
  import phi_pkg::*;
#(
  parameter int WAIT_LEN = PHI_WAIT_LEN_DEF
)
(
  // clock and reset
  input wire logic CLK_I,
  input wire logic RST_N_I,
  // host driven
  input wire logic cs_n,
  input wire logic write_n,
  input wire logic read_n,
  input wire logic write_strobe_upper_n,
  input wire logic write_strobe_lower_n,
  input wire logic read_strobe_upper_n,
  input wire logic read_strobe_lower_n,
  input wire logic upper_data_strobe_n,
  input wire logic lower_data_strobe_n,
  input wire logic read_not_write,
  input wire logic h_data_oe,
  // device driven
  input wire logic [15:0] d_data_o,
  input wire logic d_data_oe,
  input wire logic d_wait_n_o,
  input wire logic d_wait_oe
);
  logic ds;
  logic wr_act;
  logic rd_act;
  logic act;
  logic [8:0] wr_len_q;
  assign ds = !upper_data_strobe_n || !lower_data_strobe_n;
  assign wr_act = !cs_n && (!write_n || !write_strobe_upper_n || !write_strobe_lower_n || (ds && !read_not_write));
  assign rd_act = !cs_n && (!read_n || !read_strobe_upper_n || !read_strobe_lower_n || (ds && read_not_write));
  assign act = wr_act || rd_act;
  // saturates so a stuck strobe cannot wrap back to a short count
  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      wr_len_q <= 9'h0;
    end else begin
      wr_len_q <= !wr_act ? 9'h0 : ((wr_len_q == 9'h1ff) ? wr_len_q : wr_len_q + 9'h1);
    end
  end
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (!RST_N_I);
  a_wait_on_strobe:
    assert property ($rose(act) |-> ##1 !d_wait_n_o) else $error("wait not low after strobe");
  a_wait_float_after:
    assert property ($fell(act) |-> ##1 !d_wait_oe) else $error("wait still driven");
  a_wait_only_access:
    assert property (d_wait_oe |-> $past(act)) else $error("wait driven outside access");
  a_wait_low_cause:
    assert property ($fell(d_wait_n_o) |-> $past(act)) else $error("wait low without strobe");
  a_data_on_read:
    assert property ($rose(rd_act) |-> ##1 d_data_oe) else $error("read data not driven");
  a_data_only_read:
    assert property (d_data_oe |-> $past(rd_act) || $past(rd_act, 2)) else $error("bus driven outside read");
  a_data_bus_release:
    assert property ($fell(rd_act) |-> ##[1:2] !d_data_oe) else $error("bus not released");
  a_no_bus_fight:
    assert property (!(d_data_oe && h_data_oe)) else $error("both ends drive data");
  a_data_held_valid:
    assert property (rd_act && $past(rd_act) && d_wait_n_o && $past(d_wait_n_o) |-> $stable(d_data_o))
      else $error("read data moved");
  a_nowait_write_len:
    assert property ($fell(wr_act) && !$past(d_wait_oe) |-> wr_len_q >= 9'(WAIT_LEN + 3))
      else $error("no-wait write too short");
  c_stalled_read: cover property ($rose(d_wait_n_o) && rd_act && d_wait_oe);
  c_nowait_write: cover property ($fell(wr_act) && !$past(d_wait_oe));
  c_read_driven: cover property ($rose(d_data_oe));
endmodule : phi_bus_assertions

`default_nettype wire

//--- testbench/test_parallel_cpu_host_interface.sv
`timescale 1ns/10ps
`default_nettype none

module test_parallel_cpu_host_interface;
  import phi_pkg::*;
  localparam int WL = 4;
  logic clk, busy, done, dreq, dwr, dmem, s_wr, s_mem;
  logic rst_n = 1'b0, wen = 1'b1, big = 1'b0, req = 1'b0, wr = 1'b0, mem = 1'b0, sel = 1'b0, ack = 1'b0;
  phi_mode_t mode = PHI_DIR80_T3;
  logic [17:0] addr = 18'h0, daddr, s_addr;
  logic [15:0] wd = 16'h0, rdw = 16'h0, rword = 16'h0, idx = 16'h0, rdata, dwd, index, s_wd;
  logic [1:0] lanes = 2'h3, dbe, s_be;
  int err_total, comparisons, n_ack, cnt, dly, tn;
  phi_bus_if bus ();
  phi_host_end #(.WAIT_LEN(WL)) phi_host_end_inst (.CLK_I(clk), .RST_N_I(rst_n), .MODE_I(mode), .WAIT_EN_I(wen),
    .REQ_I(req), .WR_I(wr), .MEM_I(mem), .SEL_I(sel), .ADDR_I(addr), .LANES_I(lanes), .WDATA_I(wd),
    .BUSY_O(busy), .DONE_O(done), .RDATA_O(rdata), .BUS(bus.host));
  phi_dev_end phi_dev_end_inst (.CLK_I(clk), .RST_N_I(rst_n), .MODE_I(mode), .WAIT_EN_I(wen), .BIG_ENDIAN_I(big),
    .BUS(bus.dev), .REQ_O(dreq), .WR_O(dwr), .MEM_O(dmem), .ADDR_O(daddr), .BE_O(dbe), .WDATA_O(dwd),
    .ACK_I(ack), .RDATA_I(rdw), .INDEX_O(index));
  phi_bus_assertions #(.WAIT_LEN(WL)) phi_bus_assertions_inst (.CLK_I(clk), .RST_N_I(rst_n), .cs_n(bus.cs_n),
    .write_n(bus.write_n), .read_n(bus.read_n), .write_strobe_upper_n(bus.write_strobe_upper_n),
    .write_strobe_lower_n(bus.write_strobe_lower_n), .read_strobe_upper_n(bus.read_strobe_upper_n),
    .read_strobe_lower_n(bus.read_strobe_lower_n), .upper_data_strobe_n(bus.upper_data_strobe_n),
    .lower_data_strobe_n(bus.lower_data_strobe_n), .read_not_write(bus.read_not_write), .h_data_oe(bus.h_data_oe),
    .d_data_o(bus.d_data_o), .d_data_oe(bus.d_data_oe), .d_wait_n_o(bus.d_wait_n_o), .d_wait_oe(bus.d_wait_oe));

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // memory stand-in: a slow answer keeps the stall up, which no-wait hosts cannot see
  always @(posedge clk) begin
    ack <= 1'b0;
    if (dreq && !ack && cnt < dly) begin
      cnt <= cnt + 1;
    end else if (dreq && !ack) begin
      ack <= 1'b1;
      cnt <= 0;
      n_ack <= n_ack + 1;
      rdw <= rword;
      {s_wr, s_mem, s_addr, s_be, s_wd} <= {dwr, dmem, daddr, dbe, dwd};
    end
  end

  task automatic chk(input string nm, input logic [17:0] got, input logic [17:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  task automatic test_done();
    $display("comparisons %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : test_done

  // one host access; expectations come from the arguments and the tracked index alone
  task automatic acc(input phi_mode_t m, input logic we, bg, w, me, s, input logic [17:0] a,
      input logic [1:0] ln, input logic [15:0] d, input int dl);
    logic ind, cmd, rg;
    logic [1:0] le, eb;
    logic [15:0] sw, pm, wm;
    int n0, k;
    ind = (m == PHI_IND80_T1);
    cmd = ind && !s;
    rg = ind ? !idx[PHI_IDX_MEM_BIT] : !me;
    le = (m == PHI_DIR80_T2 && !w) ? PHI_LANES_ALL : ln;
    eb = (ind && rg) ? PHI_LANES_ALL : (bg ? {le[0], le[1]} : le);
    sw = bg ? {d[7:0], d[15:8]} : d;
    pm = {{8{le[1]}}, {8{le[0]}}};
    wm = bg ? {pm[7:0], pm[15:8]} : pm;
    n0 = n_ack;
    dly = dl;
    @(posedge clk);
    mode <= m;
    {wen, big, wr, mem, sel, addr, lanes, wd, rword} <= {we, bg, w, me, s, a, ln, d, sw};
    req <= 1'b1;
    @(posedge clk);
    req <= 1'b0;
    #1;
    chk("busy", {17'h0, busy}, 18'h1);
    for (k = 0; k < 600 && done !== 1'b1; k++) begin
      @(posedge clk);
      #1;
    end
    if (k == 600) begin
      chk("done", {17'h0, done}, 18'h1);
      test_done();
    end
    chk("busy", {17'h0, busy}, 18'h0);
    if (cmd) begin
      idx = d;
      chk("index", {2'h0, index}, {2'h0, d});
      chk("requests", 18'(n_ack - n0), 18'h0);
    end else begin
      chk("requests", 18'(n_ack - n0), 18'h1);
      chk("direction", {17'h0, s_wr}, {17'h0, w});
      chk("space", {17'h0, s_mem}, {17'h0, !rg});
      chk("address", s_addr, ind ? {3'h0, idx[14:0]} : a);
      chk("lanes", {16'h0, s_be}, {16'h0, eb});
      if (w) chk("wdata", {2'h0, s_wd & wm}, {2'h0, sw & wm});
      else chk("rdata", {2'h0, rdata & pm}, {2'h0, d & pm});
    end
    tn++;
    $display("test %0d done", tn);
  endtask : acc

  initial begin
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    acc(PHI_DIR80_T3, 1'b1, 1'b0, 1'b1, 1'b1, 1'b0, 18'h3ffff, 2'h3, 16'ha55a, 3);
    acc(PHI_DIR80_T3, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 18'h00001, 2'h2, 16'hc3f0, 0);
    acc(PHI_DIR80_T3, 1'b1, 1'b0, 1'b0, 1'b1, 1'b0, 18'h00100, 2'h1, 16'h1234, 5);
    acc(PHI_DIR80_T3, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 18'h00002, 2'h3, 16'hbeef, 1);
    acc(PHI_DIR80_T2, 1'b0, 1'b0, 1'b1, 1'b1, 1'b0, 18'h2aaaa, 2'h1, 16'h00ff, 0);
    acc(PHI_DIR80_T2, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 18'h15555, 2'h1, 16'h5a3c, 0);
    acc(PHI_DIR68, 1'b1, 1'b0, 1'b1, 1'b1, 1'b0, 18'h00040, 2'h2, 16'h1357, 2);
    acc(PHI_DIR68, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 18'h00041, 2'h3, 16'h2468, 0);
    acc(PHI_IND80_T1, 1'b1, 1'b0, 1'b1, 1'b0, 1'b0, 18'h0, 2'h3, 16'h8012, 0);
    acc(PHI_IND80_T1, 1'b1, 1'b1, 1'b1, 1'b0, 1'b1, 18'h0, 2'h1, 16'habcd, 2);
    acc(PHI_IND80_T1, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 18'h0, 2'h2, 16'h6789, 0);
    acc(PHI_IND80_T1, 1'b1, 1'b0, 1'b1, 1'b0, 1'b0, 18'h0, 2'h1, 16'h0034, 0);
    acc(PHI_IND80_T1, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 18'h0, 2'h2, 16'h4321, 4);
    acc(PHI_IND80_T1, 1'b0, 1'b1, 1'b0, 1'b0, 1'b1, 18'h0, 2'h1, 16'h9abc, 0);
    acc(PHI_DIR80_T2, 1'b1, 1'b0, 1'b1, 1'b0, 1'b0, 18'h00003, 2'h3, 16'h0f0f, 8);
    acc(PHI_DIR80_T3, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 18'h3fffe, 2'h2, 16'h7e81, 0);
    test_done();
  end
endmodule : test_parallel_cpu_host_interface

`default_nettype wire
